// [src/rmsc_top.sv]
`timescale 1ns/1ns
// Function
// R1: I2C mode takes per-lane swing from registers, separate for 1.4 and 2.0 rates.
// R2: strap swing covers clock lane at 1.4 and FRL; 2.0 clock lane stays default.
// R3: swing strap 0,R,F,1 maps to default, -5%, +5%, +10% per rate; code: 0 default (+10% FRL), R -5%, F default, 1 +5% (default at 1.4).
// R4: pin-strap linear fixes range at 1200 mVpp; I2C takes range from register.
// R5: clock split at 1.4/2.0 drives separate clock output, clock lane off.
// R6: clock split in FRL puts data lane 3 on clock lane, separate output off.
// R7: clock split on with mode strap R, or register bit in I2C mode.
// R8: lane swap always forces clock split off.
// R9: mode strap picks three pin modes or I2C at F; snooping per mode.
// R10: I2C mode takes address from address strap, other straps ignored; code still applies the equalizer and hot-plug output style straps.
// R11: I2C mode starts powered down; hot-plug output low while request bit set.
// R12: coupling low: config-0 low gives auto 1.4 termination, high forces 300 ohm.
// R13: coupling high with config-0 high enters alternate display mode.
// R14: data/config strap 0 keeps lane order, 1 swaps lanes.
// R15: config-0 sampled continuously, other two-level straps latched once.
// R16: integrator uses linear operation in alternate display mode.
// R17: pin 1.4/2.0 operation applies sampled equalizer strap via active map.
// R18: limited operation fixes levels from straps; linear follows the input.
// R19: mode 0 uses fixed equalization; limited FRL held at TXFFE0.
// R20: mode 1 allows adaptive equalization; limited FRL stays at TXFFE0.
// R21: mode R equals mode 1 plus clock split.
// R22: integrator prefers linear at mode R, limited for source 1.4/2.0.
// R23: snoop-following FRL limited applies de-emphasis from snooped TXFFE level.
// R24: four-level straps decode to 0,R,F,1 and are latched after power-up.
module rmsc_top
  import rmsc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_link_i,
  input wire logic [1:0] mode_strap_i,
  input wire logic [1:0] swing_strap_pin_i,
  input wire logic [1:0] emphasis_strap_pin_i,
  input wire logic [1:0] address_strap_i,
  input wire logic [1:0] equalizer_strap_i,
  input wire logic serial_clock_config_strap_i,
  input wire logic serial_data_lane_strap_i,
  input wire logic coupling_select_pin_i,
  input wire logic hotplug_output_style_i,
  input wire logic linear_select_pin_i,
  input wire logic hotplug_input_i,
  input wire logic [1:0] snoop_rate_i,
  input wire logic [1:0] snoop_txffe_i,
  input wire logic link_freq_high_i,
  input wire logic [15:0] legacy_rate_swing_setting_i,
  input wire logic [15:0] high_rate_swing_setting_i,
  input wire logic [1:0] linear_range_setting_i,
  input wire logic clock_split_enable_i,
  input wire logic snoop_disable_i,
  input wire logic power_down_request_i,
  input wire logic linear_setting_i,
  input wire logic lane_swap_setting_i,
  input wire logic adaptive_equalizer_setting_i,
  input wire logic txffe_follow_setting_i,
  input wire logic [1:0] term_setting_i,
  output logic i2c_mode_o,
  output logic [6:0] i2c_address_o,
  output logic snoop_enable_o,
  output logic lane_swap_o,
  output logic clock_split_o,
  output logic separate_clock_output_en_o,
  output logic clock_lane_output_en_o,
  output logic clock_lane_carries_d3_o,
  output logic linear_o,
  output logic [1:0] linear_range_o,
  output logic [15:0] lane_swing_o,
  output logic [1:0] emphasis_sel_o,
  output logic deemph_active_o,
  output logic [1:0] deemph_level_o,
  output logic [1:0] eq_setting_o,
  output logic adaptive_equalizer_o,
  output logic eq_map_12g_o,
  output logic [1:0] term_sel_o,
  output logic alt_display_o,
  output logic all_lanes_on_o,
  output logic hotplug_output_style_o,
  output logic power_down_o,
  output logic hotplug_output_o,
  output logic straps_ready_o
);

  function automatic rmsc_lvl_t lvl_dec(input logic [1:0] code);
    lvl_dec = rmsc_lvl_t'(code);
  endfunction : lvl_dec

  // pin synchronisers
  logic [13:0] pins_s;
  logic [1:0] mode_s;
  logic [1:0] swg_s;
  logic [1:0] emph_s;
  logic [1:0] addr_s;
  logic [1:0] eq_s;
  logic cfg0_s;
  logic lane_s;
  logic cpl_s;
  logic hstyle_s;
  logic lin_s;
  logic hpd_s;

  rmsc_sync2 #(.W(14)) u_pin_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i({mode_strap_i, swing_strap_pin_i, emphasis_strap_pin_i, address_strap_i,
          equalizer_strap_i, serial_clock_config_strap_i, serial_data_lane_strap_i,
          coupling_select_pin_i, hotplug_output_style_i}),
    .q_o(pins_s)
  );

  rmsc_sync2 #(.W(2)) u_lvl_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i({linear_select_pin_i, hotplug_input_i}),
    .q_o({lin_s, hpd_s})
  );

  assign {mode_s, swg_s, emph_s, addr_s, eq_s, cfg0_s, lane_s, cpl_s, hstyle_s} = pins_s;

  // link domain: capture snoop results, toggle on change
  logic [4:0] link_data_ff;
  logic [4:0] nxt_link_data;
  logic link_tog_ff;
  logic nxt_link_tog;

  always_comb
  begin
    nxt_link_data = link_data_ff;
    nxt_link_tog = link_tog_ff;
    if ({snoop_rate_i, snoop_txffe_i, link_freq_high_i} != link_data_ff)
    begin
      nxt_link_data = {snoop_rate_i, snoop_txffe_i, link_freq_high_i};
      nxt_link_tog = !link_tog_ff;
    end
  end

  always_ff @(posedge clk_link_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link_data_ff <= '0;
      link_tog_ff <= 1'b0;
    end
    else
    begin
      link_data_ff <= nxt_link_data;
      link_tog_ff <= nxt_link_tog;
    end
  end

  // limitation: a second change within the sync delay may be seen early, and the first change lost
  logic tog_s;
  rmsc_sync2 #(.W(1)) u_tog_sync (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(link_tog_ff),
    .q_o(tog_s)
  );

  // system domain state
  logic tog_seen_ff, nxt_tog_seen;
  logic [4:0] snoop_ff, nxt_snoop;
  logic [1:0] settle_ff, nxt_settle;
  logic done_ff, nxt_done;
  rmsc_lvl_t mode_lat_ff, nxt_mode_lat;
  rmsc_lvl_t swg_lat_ff, nxt_swg_lat;
  rmsc_lvl_t emph_lat_ff, nxt_emph_lat;
  rmsc_lvl_t addr_lat_ff, nxt_addr_lat;
  logic [1:0] eq_lat_ff, nxt_eq_lat;
  logic lane_lat_ff, nxt_lane_lat;
  logic cpl_lat_ff, nxt_cpl_lat;
  logic hstyle_lat_ff, nxt_hstyle_lat;
  logic lin_lat_ff, nxt_lin_lat;
  logic [1:0] rate;
  logic [1:0] txffe;
  logic freq_high;

  assign {rate, txffe, freq_high} = snoop_ff;

  always_comb
  begin
    nxt_tog_seen = tog_s;
    nxt_snoop = snoop_ff;
    if (tog_s != tog_seen_ff)
    begin
      nxt_snoop = link_data_ff;
    end
    nxt_settle = settle_ff;
    nxt_done = done_ff;
    nxt_mode_lat = mode_lat_ff;
    nxt_swg_lat = swg_lat_ff;
    nxt_emph_lat = emph_lat_ff;
    nxt_addr_lat = addr_lat_ff;
    nxt_eq_lat = eq_lat_ff;
    nxt_lane_lat = lane_lat_ff;
    nxt_cpl_lat = cpl_lat_ff;
    nxt_hstyle_lat = hstyle_lat_ff;
    nxt_lin_lat = lin_lat_ff;
    if (!done_ff)
    begin
      nxt_settle = settle_ff + 2'h1;
      if (settle_ff == STRAP_SETTLE)
      begin
        // straps are caught once, after the synchronisers have filled
        nxt_done = 1'b1; // [R24]
        nxt_mode_lat = lvl_dec(mode_s); // [R24]
        nxt_swg_lat = lvl_dec(swg_s);
        nxt_emph_lat = lvl_dec(emph_s);
        nxt_addr_lat = lvl_dec(addr_s);
        nxt_eq_lat = eq_s;
        nxt_lane_lat = lane_s; // [R15]
        nxt_cpl_lat = cpl_s;
        nxt_hstyle_lat = hstyle_s;
        nxt_lin_lat = lin_s;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tog_seen_ff <= 1'b0;
      snoop_ff <= '0;
      settle_ff <= '0;
      done_ff <= 1'b0;
      mode_lat_ff <= LVL_F;
      swg_lat_ff <= LVL_F;
      emph_lat_ff <= LVL_F;
      addr_lat_ff <= LVL_0;
      eq_lat_ff <= '0;
      lane_lat_ff <= 1'b0;
      cpl_lat_ff <= 1'b0;
      hstyle_lat_ff <= 1'b0;
      lin_lat_ff <= 1'b0;
    end
    else
    begin
      tog_seen_ff <= nxt_tog_seen;
      snoop_ff <= nxt_snoop;
      settle_ff <= nxt_settle;
      done_ff <= nxt_done;
      mode_lat_ff <= nxt_mode_lat;
      swg_lat_ff <= nxt_swg_lat;
      emph_lat_ff <= nxt_emph_lat;
      addr_lat_ff <= nxt_addr_lat;
      eq_lat_ff <= nxt_eq_lat;
      lane_lat_ff <= nxt_lane_lat;
      cpl_lat_ff <= nxt_cpl_lat;
      hstyle_lat_ff <= nxt_hstyle_lat;
      lin_lat_ff <= nxt_lin_lat;
    end
  end

  // mode decode and outputs
  logic nxt_i2c, nxt_snoop_en, nxt_swap, nxt_split, nxt_sep_en, nxt_clk_en, nxt_d3;
  logic nxt_linear, nxt_deemph_act, nxt_adapt, nxt_map12, nxt_alt, nxt_all_on;
  logic nxt_pd, nxt_hotplug_output, nxt_hstyle;
  logic [1:0] nxt_range, nxt_emph, nxt_deemph, nxt_eq, nxt_term;
  logic [6:0] nxt_addr;
  logic [15:0] nxt_swing;
  logic [3:0] strap_swg;
  logic i2c_mode_ff, snoop_enable_ff, lane_swap_ff, clock_split_ff, sep_en_ff, clk_en_ff;
  logic d3_ff, linear_ff, deemph_act_ff, adapt_ff, map12_ff, alt_ff, all_on_ff;
  logic pd_ff, hotplug_output_ff, hstyle_ff;
  logic [1:0] range_ff, emph_ff, deemph_ff, eq_ff, term_ff;
  logic [6:0] addr_ff;
  logic [15:0] swing_ff;

  always_comb
  begin
    nxt_i2c = (mode_lat_ff == LVL_F); // [R9]
    nxt_addr = I2C_ADDR_BASE | {5'h00, addr_lat_ff}; // [R10]
    nxt_alt = !nxt_i2c && cpl_lat_ff && cfg0_s; // [R13]
    // alternate display relies on the board strapping linear operation [R16]
    nxt_all_on = nxt_alt && hpd_s; // [R13]
    nxt_map12 = nxt_alt; // [R13]
    nxt_snoop_en = nxt_i2c ? !snoop_disable_i : !nxt_alt; // [R9]
    nxt_swap = nxt_i2c ? lane_swap_setting_i : lane_lat_ff; // [R14]
    nxt_split = nxt_i2c ? clock_split_enable_i : (mode_lat_ff == LVL_R); // [R7] [R21]
    if (nxt_swap)
    begin
      nxt_split = 1'b0; // [R8]
    end
    nxt_sep_en = nxt_split && (rate != RATE_FRL); // [R5]
    nxt_clk_en = !nxt_sep_en; // [R5]
    nxt_d3 = nxt_split && (rate == RATE_FRL); // [R6]
    nxt_linear = nxt_i2c ? linear_setting_i : lin_lat_ff;
    nxt_range = nxt_i2c ? linear_range_setting_i : LIN_RANGE_MAX; // [R4]
    // swing strap decode per rate
    case (swg_lat_ff)
      LVL_0: strap_swg = (rate == RATE_FRL) ? SWG_P10 : SWG_DEF; // [R3]
      LVL_R: strap_swg = SWG_M5; // [R3]
      LVL_1: strap_swg = (rate == RATE_14) ? SWG_DEF : SWG_P5; // [R3]
      default: strap_swg = SWG_DEF;
    endcase
    for (int i = 0; i < LANES; i++)
    begin
      if (nxt_i2c)
      begin
        nxt_swing[i*SWG_W +: SWG_W] = (rate == RATE_14) ? // [R1]
          legacy_rate_swing_setting_i[i*SWG_W +: SWG_W] :
          high_rate_swing_setting_i[i*SWG_W +: SWG_W];
      end
      else if (nxt_linear)
      begin
        nxt_swing[i*SWG_W +: SWG_W] = SWG_LIN; // [R4] [R18]
      end
      else if (i == CLK_LANE && rate == RATE_20)
      begin
        nxt_swing[i*SWG_W +: SWG_W] = SWG_DEF; // [R2]
      end
      else
      begin
        nxt_swing[i*SWG_W +: SWG_W] = strap_swg; // [R2] [R18]
      end
    end
    // pre-emphasis strap only applies to limited 1.4/2.0 in pin modes
    nxt_emph = (!nxt_i2c && !nxt_linear && rate != RATE_FRL) ? emph_lat_ff : LVL_F; // [R18]
    nxt_deemph_act = !nxt_linear && (rate == RATE_FRL);
    nxt_deemph = TXFFE_LVL0; // [R19] [R20]
    if (nxt_i2c && txffe_follow_setting_i)
    begin
      nxt_deemph = txffe; // [R23]
    end
    nxt_eq = eq_lat_ff; // [R17]
    nxt_adapt = nxt_i2c ? adaptive_equalizer_setting_i :
      (mode_lat_ff == LVL_1 || mode_lat_ff == LVL_R); // [R19] [R20] [R21]
    if (nxt_i2c)
    begin
      nxt_term = term_setting_i;
    end
    else if (cpl_lat_ff)
    begin
      nxt_term = TERM_REG;
    end
    else if (cfg0_s)
    begin
      nxt_term = TERM_R300; // [R12] [R15]
    end
    else
    begin
      nxt_term = freq_high ? TERM_R300 : TERM_OPEN; // [R12]
    end
    nxt_pd = nxt_i2c && power_down_request_i; // [R11]
    nxt_hotplug_output = nxt_pd ? 1'b0 : hpd_s; // [R11]
    nxt_hstyle = hstyle_lat_ff;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      {i2c_mode_ff, snoop_enable_ff, lane_swap_ff, clock_split_ff} <= '0;
      {sep_en_ff, d3_ff, linear_ff, deemph_act_ff, adapt_ff, map12_ff} <= '0;
      {alt_ff, all_on_ff, hotplug_output_ff, hstyle_ff} <= '0;
      clk_en_ff <= 1'b1;
      pd_ff <= RST_POWER_DOWN; // [R11]
      {range_ff, emph_ff, deemph_ff, eq_ff, term_ff} <= '0;
      addr_ff <= I2C_ADDR_BASE;
      swing_ff <= RST_SWING;
    end
    else if (done_ff)
    begin
      {i2c_mode_ff, snoop_enable_ff, lane_swap_ff, clock_split_ff} <=
        {nxt_i2c, nxt_snoop_en, nxt_swap, nxt_split};
      {sep_en_ff, d3_ff, linear_ff, deemph_act_ff, adapt_ff, map12_ff} <=
        {nxt_sep_en, nxt_d3, nxt_linear, nxt_deemph_act, nxt_adapt, nxt_map12};
      {alt_ff, all_on_ff, hotplug_output_ff, hstyle_ff} <= {nxt_alt, nxt_all_on, nxt_hotplug_output, nxt_hstyle};
      clk_en_ff <= nxt_clk_en;
      pd_ff <= nxt_pd;
      {range_ff, emph_ff, deemph_ff, eq_ff, term_ff} <=
        {nxt_range, nxt_emph, nxt_deemph, nxt_eq, nxt_term};
      addr_ff <= nxt_addr;
      swing_ff <= nxt_swing;
    end
  end

  assign i2c_mode_o = i2c_mode_ff;
  assign i2c_address_o = addr_ff;
  assign snoop_enable_o = snoop_enable_ff;
  assign lane_swap_o = lane_swap_ff;
  assign clock_split_o = clock_split_ff;
  assign separate_clock_output_en_o = sep_en_ff;
  assign clock_lane_output_en_o = clk_en_ff;
  assign clock_lane_carries_d3_o = d3_ff;
  assign linear_o = linear_ff;
  assign linear_range_o = range_ff;
  assign lane_swing_o = swing_ff;
  assign emphasis_sel_o = emph_ff;
  assign deemph_active_o = deemph_act_ff;
  assign deemph_level_o = deemph_ff;
  assign eq_setting_o = eq_ff;
  assign adaptive_equalizer_o = adapt_ff;
  assign eq_map_12g_o = map12_ff;
  assign term_sel_o = term_ff;
  assign alt_display_o = alt_ff;
  assign all_lanes_on_o = all_on_ff;
  assign hotplug_output_style_o = hstyle_ff;
  assign power_down_o = pd_ff;
  assign hotplug_output_o = hotplug_output_ff;
  assign straps_ready_o = done_ff;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_cfg0_high_pin;
    done_ff && (mode_lat_ff != LVL_F) && !cpl_lat_ff && cfg0_s;
  endsequence

  AST_SWAP_KILLS_SPLIT: assert property (lane_swap_o |-> !clock_split_o) // [R8]
    else $error("clock split on while lanes swapped");
  AST_SPLIT_LEGACY: assert property ((clock_split_o && !clock_lane_carries_d3_o)
    |-> separate_clock_output_en_o && !clock_lane_output_en_o) // [R5]
    else $error("split in legacy rate did not move the clock");
  AST_SPLIT_FRL: assert property (clock_lane_carries_d3_o
    |-> clock_split_o && !separate_clock_output_en_o && clock_lane_output_en_o) // [R6]
    else $error("split in frl drove the separate output");
  AST_PD_HPD: assert property (power_down_o |-> !hotplug_output_o) // [R11]
    else $error("hot-plug output high in power down");
  AST_PIN_SNOOP: assert property ($past(straps_ready_o) && !i2c_mode_o && !alt_display_o
    |-> snoop_enable_o) // [R9]
    else $error("snooping off in a pin mode");
  AST_LIN_RANGE: assert property (($past(straps_ready_o) && !i2c_mode_o)
    |-> linear_range_o == LIN_RANGE_MAX) // [R4]
    else $error("pin mode linear range not at top");
  AST_CFG0_TERM: assert property (s_cfg0_high_pin |=> term_sel_o == TERM_R300) // [R12]
    else $error("config-0 high did not force 300 ohm");
  AST_ALT_SNOOP: assert property (alt_display_o |-> !snoop_enable_o && eq_map_12g_o) // [R13]
    else $error("alternate display kept snooping");
  AST_STRAP_HOLD: assert property ((straps_ready_o && $past(straps_ready_o, 2) && !i2c_mode_o)
    |-> $stable(lane_swap_o)) // [R15]
    else $error("latched lane swap strap changed");
  AST_START_PD: assert property (i2c_mode_o && $past(power_down_request_i) // [R11]
    |-> power_down_o) else $error("power down left while the request bit was set");

endmodule : rmsc_top

// [pkg/rmsc_pkg.sv]
package rmsc_pkg;

  // four-level strap states, pins report them as a 2-bit level code
  typedef enum logic [1:0] {LVL_0, LVL_R, LVL_F, LVL_1} rmsc_lvl_t;

  // snooped link rate
  localparam logic [1:0] RATE_14 = 2'h0;
  localparam logic [1:0] RATE_20 = 2'h1;
  localparam logic [1:0] RATE_FRL = 2'h2;

  // per-lane swing codes (4 bits per lane, lane 3 is the clock lane)
  localparam logic [3:0] SWG_DEF = 4'h0;
  localparam logic [3:0] SWG_M5 = 4'h1;
  localparam logic [3:0] SWG_P5 = 4'h2;
  localparam logic [3:0] SWG_P10 = 4'h3;
  localparam logic [3:0] SWG_LIN = 4'h4;
  localparam int SWG_W = 4;
  localparam int LANES = 4;
  localparam int CLK_LANE = 3;

  // swing reference levels in mV, and the top linear range code
  localparam int SWING_DEF_MV = 1000;
  localparam int LIN_RANGE_MVPP = 1200;
  localparam logic [1:0] LIN_RANGE_MAX = 2'h3;

  // termination select
  localparam logic [1:0] TERM_OPEN = 2'h0;
  localparam logic [1:0] TERM_R300 = 2'h1;
  localparam logic [1:0] TERM_REG = 2'h2;

  // de-emphasis index: 0..3 -> -2.5, -3.5, -3.7, -4.6 dB
  localparam logic [1:0] TXFFE_LVL0 = 2'h0;

  // target address base, low two bits come from the address strap level
  localparam logic [6:0] I2C_ADDR_BASE = 7'h5c;

  // cycles after reset release before straps are latched
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // reset values
  localparam logic RST_POWER_DOWN = 1'b1;
  localparam logic [15:0] RST_SWING = 16'h0000;

endpackage : rmsc_pkg

// [src/rmsc_sync2.sv]
`timescale 1ns/1ns
module rmsc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule : rmsc_sync2

// [verif/rmsc_link_model.sv]
`timescale 1ns/1ns
// far-side snoop source: presents rate, TXFFE and clock-frequency results on the link clock
module rmsc_link_model
  import rmsc_pkg::*;
(
  input wire logic clk_link_i,
  input wire logic rst_n_i,
  input wire logic [1:0] rate_req_i,
  input wire logic [1:0] txffe_req_i,
  input wire logic freq_req_i,
  output logic [1:0] snoop_rate_o,
  output logic [1:0] snoop_txffe_o,
  output logic freq_high_o
);
  // the three results change together on one link edge, so the sys side never sees a torn set
  always_ff @(posedge clk_link_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      snoop_rate_o <= RATE_14;
      snoop_txffe_o <= TXFFE_LVL0;
      freq_high_o <= 1'b0;
    end
    else
    begin
      snoop_rate_o <= rate_req_i;
      snoop_txffe_o <= txffe_req_i;
      freq_high_o <= freq_req_i;
    end
  end
endmodule : rmsc_link_model

// [verif/tb_top.sv]
`timescale 1ns/1ns
module tb_top
  import rmsc_pkg::*;
;
  logic clk_sys_i = 0, clk_link_i = 0, rst_n_i = 0;
  logic [1:0] mode_strap_i, swing_strap_pin_i, emphasis_strap_pin_i, address_strap_i;
  logic [1:0] equalizer_strap_i, snoop_rate_i, snoop_txffe_i, linear_range_setting_i;
  logic [1:0] term_setting_i, rate_req, ffe_req;
  logic serial_clock_config_strap_i, serial_data_lane_strap_i, coupling_select_pin_i;
  logic hotplug_output_style_i, linear_select_pin_i, hotplug_input_i, link_freq_high_i;
  logic [15:0] legacy_rate_swing_setting_i, high_rate_swing_setting_i;
  logic clock_split_enable_i, snoop_disable_i, power_down_request_i, linear_setting_i;
  logic lane_swap_setting_i, adaptive_equalizer_setting_i, txffe_follow_setting_i, freq_req;
  logic i2c_mode_o, snoop_enable_o, lane_swap_o, clock_split_o, separate_clock_output_en_o;
  logic clock_lane_output_en_o, clock_lane_carries_d3_o, linear_o, deemph_active_o;
  logic adaptive_equalizer_o, eq_map_12g_o, alt_display_o, all_lanes_on_o;
  logic hotplug_output_style_o, power_down_o, hotplug_output_o, straps_ready_o;
  logic [6:0] i2c_address_o;
  logic [1:0] linear_range_o, emphasis_sel_o, deemph_level_o, eq_setting_o, term_sel_o;
  logic [15:0] lane_swing_o;
  int fails = 0, checks = 0, cycles = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  // 15 ns link clock, offset so its edges never meet a system clock edge
  initial
  begin
    #1;
    forever
    begin
      #7 clk_link_i = 1'b1;
      #8 clk_link_i = 1'b0;
    end
  end

  rmsc_top dut (.*);
  rmsc_link_model link (.clk_link_i(clk_link_i), .rst_n_i(rst_n_i), .rate_req_i(rate_req),
    .txffe_req_i(ffe_req), .freq_req_i(freq_req), .snoop_rate_o(snoop_rate_i),
    .snoop_txffe_o(snoop_txffe_i), .freq_high_o(link_freq_high_i));

  task automatic report_and_stop;
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc

  // straps must already be set; they are latched once after release
  task automatic do_reset;
    int n;
    n = 0;
    rst_n_i <= 1'b0;
    cyc(20);
    rst_n_i <= 1'b1;
    while (straps_ready_o !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk(16'(straps_ready_o), 16'h0001);
    cyc(3);
  endtask : do_reset

  // snoop results need a few sys cycles to cross
  task automatic set_link(input logic [1:0] r, input logic [1:0] f, input logic fh);
    rate_req <= r;
    ffe_req <= f;
    freq_req <= fh;
    cyc(14);
  endtask : set_link

  function automatic logic [3:0] swg_exp(logic [1:0] lvl, logic [1:0] rate, bit clk);
    if (rate == RATE_20 && clk)
      return SWG_DEF;
    case (lvl)
      2'h0: return (rate == RATE_FRL) ? SWG_P10 : SWG_DEF;
      2'h1: return SWG_M5;
      2'h2: return SWG_DEF;
      default: return (rate == RATE_14) ? SWG_DEF : SWG_P5;
    endcase
  endfunction : swg_exp

  task automatic t_swing;
    logic [1:0] r;
    for (int l = 0; l < 4; l++)
    begin
      swing_strap_pin_i <= 2'(l);
      emphasis_strap_pin_i <= 2'(l);
      do_reset();
      for (int k = 0; k < 3; k++)
      begin
        r = 2'(k);
        set_link(r, 2'h0, 1'b0);
        for (int i = 0; i < LANES; i++)
          chk(16'(lane_swing_o[i*SWG_W +: SWG_W]), 16'(swg_exp(2'(l), r, i == CLK_LANE)));
        if (r == RATE_14)
          chk(16'(emphasis_sel_o), 16'(l));
      end
    end
    emphasis_strap_pin_i <= 2'h0;
    linear_select_pin_i <= 1'b1;
    do_reset();
    chk({linear_o, 13'h0, linear_range_o}, {1'b1, 13'h0, LIN_RANGE_MAX});
    chk(lane_swing_o, {4{SWG_LIN}});
    linear_select_pin_i <= 1'b0;
  endtask : t_swing

  task automatic t_split;
    mode_strap_i <= 2'h1;
    linear_select_pin_i <= 1'b1;
    set_link(RATE_14, 2'h0, 1'b0);
    do_reset();
    chk({clock_split_o, separate_clock_output_en_o, clock_lane_output_en_o}, 16'h0006);
    chk(16'(adaptive_equalizer_o), 16'h0001);
    set_link(RATE_FRL, 2'h0, 1'b0);
    chk({clock_lane_carries_d3_o, separate_clock_output_en_o, clock_lane_output_en_o}, 16'h0005);
    serial_data_lane_strap_i <= 1'b1;
    cyc(8);
    chk({lane_swap_o, clock_split_o}, 16'h0001);
    do_reset();
    chk({lane_swap_o, clock_split_o, separate_clock_output_en_o}, 16'h0004);
    {serial_data_lane_strap_i, linear_select_pin_i} <= 2'h0;
  endtask : t_split

  task automatic t_i2c;
    mode_strap_i <= 2'h2;
    address_strap_i <= 2'h1;
    swing_strap_pin_i <= 2'h3;
    power_down_request_i <= 1'b1;
    legacy_rate_swing_setting_i <= 16'h0123;
    high_rate_swing_setting_i <= 16'h4321;
    set_link(RATE_14, 2'h0, 1'b0);
    do_reset();
    chk({i2c_mode_o, 8'h0, i2c_address_o}, {1'b1, 8'h0, I2C_ADDR_BASE | 7'h01});
    chk({power_down_o, hotplug_output_o}, 16'h0002);
    chk(lane_swing_o, 16'h0123);
    power_down_request_i <= 1'b0;
    cyc(3);
    chk({power_down_o, hotplug_output_o, snoop_enable_o}, 16'h0003);
    snoop_disable_i <= 1'b1;
    clock_split_enable_i <= 1'b1;
    linear_setting_i <= 1'b1;
    linear_range_setting_i <= 2'h1;
    term_setting_i <= 2'h2;
    set_link(RATE_20, 2'h0, 1'b0);
    chk(lane_swing_o, 16'h4321);
    chk({snoop_enable_o, clock_split_o, linear_o, 11'h0, linear_range_o}, 16'h6001);
    chk(16'(term_sel_o), 16'h0002);
    lane_swap_setting_i <= 1'b1;
    cyc(3);
    chk({lane_swap_o, clock_split_o}, 16'h0002);
    txffe_follow_setting_i <= 1'b1;
    adaptive_equalizer_setting_i <= 1'b1;
    set_link(RATE_FRL, 2'h2, 1'b0);
    chk({adaptive_equalizer_o, 13'h0, deemph_level_o}, 16'h8002);
    chk(lane_swing_o, 16'h4321);
    {txffe_follow_setting_i, adaptive_equalizer_setting_i} <= 2'h0;
    mode_strap_i <= 2'h3;
  endtask : t_i2c

  task automatic t_term;
    set_link(RATE_14, 2'h0, 1'b0);
    do_reset();
    chk(16'(term_sel_o), 16'(TERM_OPEN));
    set_link(RATE_14, 2'h0, 1'b1);
    chk(16'(term_sel_o), 16'(TERM_R300));
    set_link(RATE_14, 2'h0, 1'b0);
    serial_clock_config_strap_i <= 1'b1;
    cyc(4);
    chk(16'(term_sel_o), 16'(TERM_R300));
    serial_clock_config_strap_i <= 1'b0;
  endtask : t_term

  task automatic t_alt;
    coupling_select_pin_i <= 1'b1;
    serial_clock_config_strap_i <= 1'b1;
    linear_select_pin_i <= 1'b1;
    hotplug_input_i <= 1'b1;
    do_reset();
    chk({alt_display_o, snoop_enable_o, eq_map_12g_o, all_lanes_on_o}, 16'h000b);
    hotplug_input_i <= 1'b0;
    cyc(4);
    chk(16'(all_lanes_on_o), 16'h0000);
    serial_clock_config_strap_i <= 1'b0;
    cyc(4);
    chk({alt_display_o, snoop_enable_o}, 16'h0001);
    coupling_select_pin_i <= 1'b0;
    linear_select_pin_i <= 1'b0;
  endtask : t_alt

  task automatic t_eq;
    mode_strap_i <= 2'h0;
    equalizer_strap_i <= 2'h2;
    hotplug_output_style_i <= 1'b1;
    set_link(RATE_FRL, 2'h3, 1'b0);
    do_reset();
    chk({eq_setting_o, adaptive_equalizer_o, 11'h0, deemph_level_o}, 16'h8000);
    chk({hotplug_output_style_o, snoop_enable_o, deemph_active_o}, 16'h0007);
    mode_strap_i <= 2'h3;
    equalizer_strap_i <= 2'h1;
    do_reset();
    chk({eq_setting_o, adaptive_equalizer_o, 11'h0, deemph_level_o}, 16'h6000);
  endtask : t_eq

  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    {mode_strap_i, swing_strap_pin_i, emphasis_strap_pin_i} = {2'h3, 4'h0};
    {address_strap_i, equalizer_strap_i, linear_range_setting_i, term_setting_i} = 8'h00;
    {rate_req, ffe_req, freq_req} = 5'h00;
    {serial_clock_config_strap_i, serial_data_lane_strap_i, coupling_select_pin_i} = 3'h0;
    {hotplug_output_style_i, linear_select_pin_i, hotplug_input_i} = 3'h1;
    {legacy_rate_swing_setting_i, high_rate_swing_setting_i} = 32'h0000_0000;
    {clock_split_enable_i, snoop_disable_i, power_down_request_i, linear_setting_i} = 4'h0;
    {lane_swap_setting_i, adaptive_equalizer_setting_i, txffe_follow_setting_i} = 3'h0;
    cyc(1);
    t_swing();
    t_split();
    t_i2c();
    t_term();
    t_alt();
    t_eq();
    report_and_stop();
  end
endmodule : tb_top
